//--- anvm_host.v
// host controller driving an asynchronous non-volatile byte memory over its pins
// assumes one 100 MHz clock; i_inhibit_level reports supply below inhibit level
// What the memory does and what this block does
// [R1] The memory holds 32,768 bytes selected by a 15-bit address, accessed one byte at a time.
// [R2] The memory drives the data bus only while selected, output-enabled and not writing.
// [R3] The memory ignores writes while its supply is below the inhibit level.
// [R4] No access is started until 2 ms after the supply is good.
// [R5] Chip select and write strobe are held high through reset and the startup wait.
// [R6] After a brownout the full startup wait is repeated before any access.
// [R7] Each read and write cycle lasts at least 35 ns.
// [R8] The write strobe stays high for the whole of a read cycle.
// [R9] The address is valid no later than the falling edge of chip select.
// [R10] A write happens while chip select and write strobe are both low, data taken at the end.
// [R11] A written byte reads back later, also across power loss.
`timescale 1ns/1ps
`include "anvm_map.vh"
module anvm_host #(
  parameter STARTUP_CYC = `ANVM_STARTUP_CYC
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_inhibit_level,
  input wire i_req,
  input wire i_we,
  input wire [`ANVM_ADDR_W-1:0] i_addr,
  input wire [`ANVM_DATA_W-1:0] i_wdata,
  output wire o_ready,
  output reg o_rvalid,
  output reg [`ANVM_DATA_W-1:0] o_rdata,
  output reg [`ANVM_ADDR_W-1:0] o_mem_addr,
  output reg o_mem_cs_n,
  output reg o_mem_oe_n,
  output reg o_mem_pgm_n,
  input wire [`ANVM_DATA_W-1:0] i_mem_dq,
  output reg [`ANVM_DATA_W-1:0] o_mem_dq,
  output reg o_mem_dq_oe
);
  localparam CNT_W = `ANVM_CNT_W;
  localparam [4:0] ST_WAIT = 5'h01;
  localparam [4:0] ST_IDLE = 5'h02;
  localparam [4:0] ST_READ = 5'h04;
  localparam [4:0] ST_WRITE = 5'h08;
  localparam [4:0] ST_END = 5'h10;
  localparam integer CYC_CLK = `ANVM_CYCLE_CYC;
  localparam integer SYNC_N = `ANVM_SYNC_DEPTH;
  localparam integer STARTUP_M1 = STARTUP_CYC - 1;
  localparam integer WRITE_M1 = CYC_CLK - 1;
  // reads run past 35 ns so the sampled pins have crossed the synchroniser
  localparam integer READ_M1 = CYC_CLK - 1 + SYNC_N;
  // counts cut to the counter width on purpose; 2 ms at 100 MHz still fits
  localparam [CNT_W-1:0] STARTUP_LAST = STARTUP_M1[CNT_W-1:0];
  localparam [CNT_W-1:0] WRITE_LAST = WRITE_M1[CNT_W-1:0];
  localparam [CNT_W-1:0] READ_LAST = READ_M1[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'h0}};

  reg [4:0] state;
  reg [4:0] next_state;
  reg [CNT_W-1:0] cnt;
  reg [CNT_W-1:0] next_cnt;
  reg inh_meta;
  reg inh_sync;
  wire [`ANVM_DATA_W-1:0] dq_sync;
  wire take;
  wire rd_done;
  wire wr_done;

  // one compare shared by the startup, read and write counts
  function cnt_hit;
    input [CNT_W-1:0] c;
    input [CNT_W-1:0] lim;
    begin
      cnt_hit = (c == lim);
    end
  endfunction

  assign o_ready = (state == ST_IDLE) && !inh_sync;
  assign take = o_ready && i_req;
  assign rd_done = (state == ST_READ) && !inh_sync && cnt_hit(cnt, READ_LAST); // R7
  assign wr_done = (state == ST_WRITE) && !inh_sync && cnt_hit(cnt, WRITE_LAST); // R7

  // supply flag is asynchronous to the clock
  always @(posedge i_clk) begin
    inh_meta <= i_inhibit_level;
    inh_sync <= inh_meta;
  end

  // each data pin gets its own two-flop stage; the bus is only taken after
  // it has been stable for most of the read, so bits cannot tear
  genvar g;
  generate
    for (g = 0; g < `ANVM_DATA_W; g = g + 1) begin : g_dq_sync
      reg [1:0] pipe;
      always @(posedge i_clk) begin
        pipe <= {pipe[0], i_mem_dq[g]};
      end
      assign dq_sync[g] = pipe[1];
    end
  endgenerate

  always @* begin
    next_state = state;
    next_cnt = cnt + 1'h1;
    if (inh_sync) begin
      // brownout: abandon any cycle and restart the full wait
      next_state = ST_WAIT; // R6
      next_cnt = CNT_ZERO;
    end else begin
      case (state)
        ST_WAIT: begin
          if (cnt_hit(cnt, STARTUP_LAST)) begin
            next_state = ST_IDLE; // R4
            next_cnt = CNT_ZERO;
          end
        end
        ST_IDLE: begin
          next_cnt = CNT_ZERO;
          if (i_req) begin
            if (i_we) begin
              next_state = ST_WRITE;
            end else begin
              next_state = ST_READ;
            end
          end
        end
        ST_READ: begin
          if (rd_done) begin
            next_state = ST_END;
          end
        end
        ST_WRITE: begin
          if (wr_done) begin
            next_state = ST_END;
          end
        end
        ST_END: begin
          // recovery clock keeps controls high between cycles
          next_state = ST_IDLE;
          next_cnt = CNT_ZERO;
        end
        default: begin
          next_state = ST_WAIT;
          next_cnt = CNT_ZERO;
        end
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_WAIT;
      cnt <= CNT_ZERO;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // controls stay high through reset, the startup wait and any brownout
  always @(posedge i_clk) begin
    if (i_rst || inh_sync) begin
      o_mem_cs_n <= 1'h1; // R5
      o_mem_pgm_n <= 1'h1; // R5
      o_mem_oe_n <= 1'h1; // R3
    end else if (take) begin
      o_mem_cs_n <= 1'h0;
      o_mem_pgm_n <= !i_we; // R8 R10
      o_mem_oe_n <= i_we;
    end else if (rd_done || wr_done) begin
      // both strobes rise together; data is latched at the end of the overlap
      o_mem_cs_n <= 1'h1; // R10
      o_mem_pgm_n <= 1'h1;
      o_mem_oe_n <= 1'h1;
    end
  end

  // address is set up on the same edge that drops the select
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_mem_addr <= {`ANVM_ADDR_W{1'h0}};
    end else if (take) begin
      o_mem_addr <= i_addr; // R1 R9
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_mem_dq <= {`ANVM_DATA_W{1'h0}};
      o_mem_dq_oe <= 1'h0;
    end else if (inh_sync) begin
      o_mem_dq_oe <= 1'h0; // R3
    end else if (take) begin
      o_mem_dq <= i_wdata;
      // never drive the pins during a read, the memory owns them then
      o_mem_dq_oe <= i_we; // R2
    end else if (state == ST_END) begin
      // data held one clock past the strobe for hold time
      o_mem_dq_oe <= 1'h0;
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rvalid <= 1'h0;
      o_rdata <= {`ANVM_DATA_W{1'h0}};
    end else begin
      o_rvalid <= rd_done;
      if (rd_done) begin
        o_rdata <= dq_sync; // R11
      end
    end
  end
endmodule // anvm_host

//--- anvm_map.vh
// timing and field constants for the byte memory host controller
// assumes a 100 MHz system clock driving the controller
`ifndef ANVM_MAP_VH
`define ANVM_MAP_VH
`define ANVM_CLK_PERIOD_NS 10
`define ANVM_ADDR_W 15
`define ANVM_DATA_W 8
`define ANVM_STARTUP_MS 2
// startup wait in cycles: 2 ms / 10 ns
`define ANVM_STARTUP_CYC ((`ANVM_STARTUP_MS * 1000000) / `ANVM_CLK_PERIOD_NS)
`define ANVM_CYCLE_NS 35
// least cycle time rounded up to whole clocks
`define ANVM_CYCLE_CYC ((`ANVM_CYCLE_NS + `ANVM_CLK_PERIOD_NS - 1) / `ANVM_CLK_PERIOD_NS)
`define ANVM_CNT_W 18
// extra read clocks spent crossing the data synchroniser
`define ANVM_SYNC_DEPTH 2
`endif

//--- anvm_mem_model.sv
// device model: byte array on the memory pins
// resolves the shared data bus from both drivers
`timescale 1ns/1ps
module anvm_mem_model(input wire [14:0] i_a, input wire i_cs_n, input wire i_oe_n,
  input wire i_pgm_n, input wire i_inh, input wire [7:0] i_hdq, input wire i_hoe,
  output wire [7:0] o_bus);
  logic [7:0] mem [0:32767];
  logic [7:0] flt = 8'h00;
  wire drv = !i_cs_n && !i_oe_n && i_pgm_n;
  always @(posedge (i_cs_n | i_pgm_n)) if (!i_inh) mem[i_a] <= i_hdq;
  // released bus shows a changed value so a late sample cannot pass
  always @(negedge drv) flt <= ~mem[i_a];
  assign o_bus = i_hoe ? i_hdq : drv ? mem[i_a] : flt;
endmodule // anvm_mem_model

//--- anvm_host_checker.sv
// pin checks on the memory host
// bound to the host top, one clock domain
`timescale 1ns/1ps
module anvm_host_checker(input wire i_clk, input wire i_rst, input wire i_inhibit_level,
  input wire o_ready, input wire o_mem_cs_n, input wire o_mem_oe_n, input wire o_mem_pgm_n,
  input wire o_mem_dq_oe, input wire [14:0] o_mem_addr);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_bus_free: assert property (!o_mem_oe_n |-> !o_mem_dq_oe)
    else $error("host drives bus in read");
  a_read_strobe: assert property (!o_mem_oe_n |-> o_mem_pgm_n)
    else $error("strobe low in read");
  a_write_len: assert property (disable iff (i_rst || i_inhibit_level)
    $fell(o_mem_pgm_n) |-> !o_mem_pgm_n[*4] ##1 o_mem_pgm_n) else $error("strobe width");
  a_select_len: assert property (disable iff (i_rst || i_inhibit_level)
    $fell(o_mem_cs_n) |-> !o_mem_cs_n[*4]) else $error("select too short");
  a_write_sel: assert property (!o_mem_pgm_n |-> !o_mem_cs_n && o_mem_dq_oe)
    else $error("strobe without select or data");
  a_addr_hold: assert property (!o_mem_cs_n && !$fell(o_mem_cs_n) |-> $stable(o_mem_addr))
    else $error("address moved");
  a_brown_idle: assert property (i_inhibit_level[*5] |-> o_mem_cs_n && o_mem_pgm_n && !o_ready)
    else $error("active in brownout");
  a_start_wait: assert property ($fell(i_inhibit_level) |-> !o_ready[*8])
    else $error("ready too soon");
endmodule // anvm_host_checker
bind anvm_host anvm_host_checker u_chk(.i_clk, .i_rst, .i_inhibit_level, .o_ready,
  .o_mem_cs_n, .o_mem_oe_n, .o_mem_pgm_n, .o_mem_dq_oe, .o_mem_addr);

//--- anvm_host_bench.sv
// bench for the memory host with a device model
// startup wait shortened to 20 cycles
`timescale 1ns/1ps
module anvm_host_bench;
  logic clk = 0, rst = 1, inh = 1, req = 0, we = 0;
  logic [14:0] addr = 15'h0000;
  logic [7:0] wd = 8'h00;
  wire ready, rvalid, cs_n, oe_n, pgm_n, hoe;
  wire [7:0] rdata, hdq, bus;
  wire [14:0] maddr;
  int error_cnt = 0, tests_run = 0;
  anvm_host #(.STARTUP_CYC(20)) dut(.i_clk(clk), .i_rst(rst), .i_inhibit_level(inh),
    .i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wd), .o_ready(ready), .o_rvalid(rvalid),
    .o_rdata(rdata), .o_mem_addr(maddr), .o_mem_cs_n(cs_n), .o_mem_oe_n(oe_n),
    .o_mem_pgm_n(pgm_n), .i_mem_dq(bus), .o_mem_dq(hdq), .o_mem_dq_oe(hoe));
  anvm_mem_model u_mem(.i_a(maddr), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_pgm_n(pgm_n),
    .i_inh(inh), .i_hdq(hdq), .i_hoe(hoe), .o_bus(bus));
  initial forever #5 clk = ~clk;
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task acc(input logic w, input logic [14:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk) #1;
    while (ready !== 1'b1 && k < 99) begin
      @(posedge clk) #1;
      k++;
    end
    chk("ready", 8'h01, {7'h00, ready});
    @(posedge clk);
    req <= 1'b1; we <= w; addr <= a; wd <= d;
    @(posedge clk);
    req <= 1'b0;
  endtask
  task rd(input logic [14:0] a, input logic [7:0] e);
    int k;
    k = 0;
    acc(1'b0, a, 8'h00);
    @(posedge clk) #1;
    while (rvalid !== 1'b1 && k < 20) begin
      @(posedge clk) #1;
      k++;
    end
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk("rdata", e, rdata);
  endtask
  task end_of_test;
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0; inh <= 1'b0;
    repeat (10) @(posedge clk) #1;
    chk("ready", 8'h00, {7'h00, ready});
    acc(1'b1, 15'h0000, 8'h5a);
    acc(1'b1, 15'h7fff, 8'ha5);
    rd(15'h0000, 8'h5a);
    rd(15'h7fff, 8'ha5);
    acc(1'b1, 15'h0000, 8'h33);
    inh <= 1'b1;
    repeat (6) @(posedge clk);
    inh <= 1'b0;
    repeat (5) @(posedge clk) #1;
    chk("ready", 8'h00, {7'h00, ready});
    rd(15'h0000, 8'h5a);
    end_of_test;
  end
  initial begin
    #20000;
    error_cnt++;
    end_of_test;
  end
endmodule // anvm_host_bench
